// *** include/dbsp_regs.svh ***
// Constants of the burst SRAM port: widths, lanes and read latencies.
// Assumes inclusion by bare name from the package and the design file.
`ifndef DBSP_REGS_SVH
`define DBSP_REGS_SVH

// Data word and byte lanes
`define DBSP_DW 36
`define DBSP_LANES 4
`define DBSP_LANE_W 9
// Burst address bits: 2M bursts of two words give 4M words
`define DBSP_AW 21
// Words per burst
`define DBSP_BURST 2
// Read latency in half cycles (one K or K# rise each)
`define DBSP_LAT_PLL 5
`define DBSP_LAT_NOPLL 2
// Depth of the read beat pipeline, in half cycles
`define DBSP_PIPE 6

`endif

// *** include/dbsp_pkg.sv ***
// Types shared by the burst SRAM port.
// Assumes dbsp_regs.svh is on the include path.
`include "dbsp_regs.svh"
`default_nettype none

package dbsp_pkg;
	// One read beat waiting in the output pipeline
	typedef struct packed {
		logic valid;
		logic [`DBSP_DW-1:0] data;
	} dbsp_beat_t;

	// One write beat as sampled from the pins
	typedef struct packed {
		logic [`DBSP_LANES-1:0] sel_n;
		logic [`DBSP_DW-1:0] data;
	} dbsp_wbeat_t;
endpackage

`default_nettype wire

// *** rtl/dbsp_port.sv ***
// Device side of a two-word burst DDR SRAM port, with its storage.
// Assumes K and K# arrive as levels sampled on core_clk_in, slower than it.
`include "dbsp_regs.svh"
`default_nettype none

// One storage array of 2**AW words with per-lane write selects
module dbsp_bank #(
	parameter int AW = `DBSP_AW
) (
	input wire logic core_clk_in,
	input wire logic ce_in,
	input wire logic we_in,
	input wire logic [AW-1:0] waddr_in,
	input wire dbsp_pkg::dbsp_wbeat_t wbeat_in,
	input wire logic [AW-1:0] raddr_in,
	output logic [`DBSP_DW-1:0] rdata_out
);
	logic [`DBSP_DW-1:0] mem [2**AW];
	logic [`DBSP_DW-1:0] next_word;

	// Merge only lanes whose select is low
	always_comb begin
		next_word = mem[waddr_in];
		for (int i = 0; i < `DBSP_LANES; i++) begin
			if (!wbeat_in.sel_n[i]) begin
				next_word[i*`DBSP_LANE_W +: `DBSP_LANE_W] =
					wbeat_in.data[i*`DBSP_LANE_W +: `DBSP_LANE_W];
			end
		end
	end

	// Storage itself carries no reset
	always_ff @(posedge core_clk_in) begin
		if (ce_in && we_in) begin
			mem[waddr_in] <= next_word;
		end
	end

	// No read-during-write bypass: a read sees the word already stored
	assign rdata_out = mem[raddr_in];

	// Lane checks written from the pin map, not from the merge loop
	a_lane0_taken: assert property (@(posedge core_clk_in)
		(ce_in && we_in && !wbeat_in.sel_n[0]) |->
		next_word[`DBSP_LANE_W-1:0] == wbeat_in.data[`DBSP_LANE_W-1:0])
		else $error("lane 0 not written from its data bits");
	a_lane3_kept: assert property (@(posedge core_clk_in)
		(ce_in && we_in && wbeat_in.sel_n[3]) |->
		next_word[`DBSP_DW-1 -: `DBSP_LANE_W] ==
		mem[waddr_in][`DBSP_DW-1 -: `DBSP_LANE_W])
		else $error("masked lane 3 was altered");
endmodule

module dbsp_port #(
	parameter int AW = `DBSP_AW
) (
	input wire logic core_clk_in,
	input wire logic nrst_in,
	input wire logic ce_in,
	input wire logic k_in,
	input wire logic k_n_in,
	input wire logic load_strobe_n_in,
	input wire logic read_write_in,
	input wire logic [AW-1:0] addr_in,
	input wire logic [`DBSP_DW-1:0] dq_in,
	input wire logic [`DBSP_LANES-1:0] byte_write_select_n_in,
	input wire logic pll_disable_n_in,
	output logic [`DBSP_DW-1:0] dq_out,
	output logic dq_oe_out,
	output logic output_valid_flag_out,
	output logic echo_clock_out,
	output logic echo_clock_n_out
);
	logic k_q, kn_q;
	logic k_rise, kn_rise, half_edge;
	logic load_rd, load_wr;
	logic wr_pend, beat1_pend;
	logic [AW-1:0] wr_addr, wr_addr2;
	logic next_wr_pend, next_beat1_pend;
	logic [AW-1:0] next_wr_addr, next_wr_addr2;
	logic we0, we1;
	dbsp_pkg::dbsp_wbeat_t wbeat;
	logic [`DBSP_DW-1:0] rd0, rd1;
	dbsp_pkg::dbsp_beat_t pipe [`DBSP_PIPE];
	dbsp_pkg::dbsp_beat_t next_pipe [`DBSP_PIPE];
	logic [`DBSP_DW-1:0] next_dq;
	logic next_oe;

	// Edge detection on the sampled input clocks
	// K# may be high at release: one spurious K# rise meets an empty
	// pipeline and no pending beat, so it has no effect
	assign k_rise = k_in && !k_q;
	assign kn_rise = k_n_in && !kn_q;
	assign half_edge = k_rise || kn_rise;
	// Commands are decoded only at K rises
	assign load_rd = k_rise && !load_strobe_n_in && read_write_in;
	assign load_wr = k_rise && !load_strobe_n_in && !read_write_in;
	// Write beat and its selects taken from the same edge
	assign wbeat.data = dq_in;
	assign wbeat.sel_n = byte_write_select_n_in;
	assign we0 = k_rise && wr_pend;
	assign we1 = kn_rise && beat1_pend;

	// First word of each burst lives in bank 0, second in bank 1
	dbsp_bank #(.AW(AW)) u_bank0 (
		.core_clk_in(core_clk_in),
		.ce_in(ce_in),
		.we_in(we0),
		.waddr_in(wr_addr),
		.wbeat_in(wbeat),
		.raddr_in(addr_in),
		.rdata_out(rd0)
	);
	dbsp_bank #(.AW(AW)) u_bank1 (
		.core_clk_in(core_clk_in),
		.ce_in(ce_in),
		.we_in(we1),
		.waddr_in(wr_addr2),
		.wbeat_in(wbeat),
		.raddr_in(addr_in),
		.rdata_out(rd1)
	);

	// Write sequencing: load, then beat 0 at K, then beat 1 at K#
	always_comb begin
		next_wr_pend = wr_pend;
		next_wr_addr = wr_addr;
		next_beat1_pend = beat1_pend;
		next_wr_addr2 = wr_addr2;
		// Retire beat 1 first, so a fresh arm in the same cycle wins
		if (kn_rise && beat1_pend) begin
			next_beat1_pend = 1'b0;
		end
		if (k_rise) begin
			next_wr_pend = load_wr;
			if (load_wr) begin
				next_wr_addr = addr_in;
			end
			if (wr_pend) begin
				next_beat1_pend = 1'b1;
				next_wr_addr2 = wr_addr;
			end
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (!nrst_in) begin
			wr_pend <= 1'b0;
			beat1_pend <= 1'b0;
			wr_addr <= '0;
			wr_addr2 <= '0;
		end else if (ce_in) begin
			wr_pend <= next_wr_pend;
			beat1_pend <= next_beat1_pend;
			wr_addr <= next_wr_addr;
			wr_addr2 <= next_wr_addr2;
		end
	end

	// Read pipeline: shifts one slot per half cycle, emits slot 0
	always_comb begin
		for (int i = 0; i < `DBSP_PIPE; i++) begin
			next_pipe[i] = pipe[i];
		end
		next_dq = dq_out;
		next_oe = dq_oe_out;
		if (half_edge) begin
			next_dq = pipe[0].data;
			next_oe = pipe[0].valid;
			for (int i = 0; i < `DBSP_PIPE - 1; i++) begin
				next_pipe[i] = pipe[i+1];
			end
			next_pipe[`DBSP_PIPE-1] = '0;
		end
		// A load writes its two slots outright; loads in one latency mode land behind beats in flight
		if (load_rd) begin
			if (pll_disable_n_in) begin
				next_pipe[`DBSP_LAT_PLL-1] = {1'b1, rd0};
				next_pipe[`DBSP_LAT_PLL] = {1'b1, rd1};
			end else begin
				next_pipe[`DBSP_LAT_NOPLL-1] = {1'b1, rd0};
				next_pipe[`DBSP_LAT_NOPLL] = {1'b1, rd1};
			end
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (!nrst_in) begin
			for (int i = 0; i < `DBSP_PIPE; i++) begin
				pipe[i] <= '0;
			end
			dq_out <= '0;
			dq_oe_out <= 1'b0;
			output_valid_flag_out <= 1'b0;
		end else if (ce_in) begin
			for (int i = 0; i < `DBSP_PIPE; i++) begin
				pipe[i] <= next_pipe[i];
			end
			dq_out <= next_dq;
			dq_oe_out <= next_oe;
			output_valid_flag_out <= next_oe;
		end
	end

	// Edge history and free running echo clocks
	always_ff @(posedge core_clk_in) begin
		if (!nrst_in) begin
			k_q <= 1'b0;
			kn_q <= 1'b0;
			echo_clock_out <= 1'b0;
			echo_clock_n_out <= 1'b0;
		end else if (ce_in) begin
			k_q <= k_in;
			kn_q <= k_n_in;
			echo_clock_out <= k_in;
			echo_clock_n_out <= k_n_in;
		end
	end

	// Checks
	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (!nrst_in);

	a_valid_with_oe: assert property (
		output_valid_flag_out == dq_oe_out)
		else $error("valid flag differs from output enable");
	a_float_when_idle: assert property (
		(ce_in && half_edge && !pipe[0].valid) |=> !dq_oe_out)
		else $error("data driven with no read beat");
	a_drive_on_half: assert property (
		$changed(dq_oe_out) |-> $past(half_edge && ce_in))
		else $error("output enable moved off a clock edge");
	a_read_pll_slot: assert property (
		(ce_in && load_rd && pll_disable_n_in) |=>
		pipe[4].valid && pipe[5].valid)
		else $error("pll read beats not scheduled at 2.5 cycles");
	a_read_nopll_slot: assert property (
		(ce_in && load_rd && !pll_disable_n_in) |=>
		pipe[1].valid && pipe[2].valid)
		else $error("read beats not scheduled at one cycle");
	a_write_two_beats: assert property (
		(ce_in && we0) |=> beat1_pend && wr_addr2 == $past(wr_addr))
		else $error("second write beat not armed");
	a_write_beat_done: assert property (
		(ce_in && we1 && !k_rise) |=> !beat1_pend)
		else $error("second write beat not retired");
	a_no_start_kn: assert property (
		(ce_in && !k_rise) |=> wr_pend == $past(wr_pend))
		else $error("write accepted off a K rise");
	a_load_addr: assert property (
		(ce_in && load_wr) |=> wr_addr == $past(addr_in) && wr_pend)
		else $error("write address not sampled at load");
	a_echo_follow: assert property (
		ce_in |=> echo_clock_out == $past(k_in))
		else $error("echo clock does not follow K");
	a_echo_n_follow: assert property (
		ce_in |=> echo_clock_n_out == $past(k_n_in))
		else $error("echo clock does not follow K#");
	a_no_load_kn: assert property (
		(ce_in && kn_rise && !k_rise) |-> !load_rd && !load_wr)
		else $error("load decoded on a K# rise");

	// Read beats leave the pipeline head only at half edges, in pairs while all loads use one latency mode
	a_beat_from_pipe: assert property (
		(ce_in && half_edge) |=> dq_out == $past(pipe[0].data))
		else $error("read beat not taken from pipeline head");
	a_beat_holds: assert property (
		(ce_in && !half_edge) |=> $stable(dq_out))
		else $error("read data moved between clock edges");
	a_oe_from_pipe: assert property (
		(ce_in && half_edge) |=> dq_oe_out == $past(pipe[0].valid))
		else $error("output enable not taken from pipeline head");
	a_read_pair: assert property (
		$rose(dq_oe_out) |-> $past(pipe[1].valid))
		else $error("first read beat without its partner");

	c_read_pll: cover property (ce_in && load_rd && pll_disable_n_in);
	c_read_nopll: cover property (ce_in && load_rd && !pll_disable_n_in);
	c_write_burst: cover property (ce_in && we0 ##[1:20] ce_in && we1);
	c_drive: cover property (dq_oe_out ##[1:20] !dq_oe_out);
	c_lane_mask: cover property (ce_in && we0 && wbeat.sel_n != 4'h0);
endmodule

`default_nettype wire

// *** tb/dbsp_ctrl_model.sv ***
// Controller-side clock source: free-running K and K# for the port.
// Assumes the bench drives commands off the falling core edge.
`default_nettype none

module dbsp_ctrl_model (
	input wire logic core_clk_in,
	output logic k_out,
	output logic k_n_out,
	output logic [2:0] phase_out
);
	timeunit 1ns;
	timeprecision 1ps;

	// Start with K low so release of reset sees no false K rise
	initial phase_out = 3'h4;

	// Eight core cycles per K period, K# half a period behind
	always @(negedge core_clk_in) begin
		phase_out <= phase_out + 3'h1;
	end

	// K and K# never rise in the same core cycle
	assign k_out = (phase_out < 3'h4);
	assign k_n_out = (phase_out >= 3'h4);
endmodule

`default_nettype wire

// *** tb/tb_top.sv ***
// Self-checking bench of the burst SRAM port, with a reference memory.
// Assumes dbsp_regs.svh on the include path and AW of 4.
`include "dbsp_regs.svh"
`default_nettype none

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int AW = 4;
	logic core_clk_in = 1'b0;
	logic nrst_in, load_n, rw, pll_n, k, kn, oe, vld, eck, ekn;
	logic [AW-1:0] addr;
	logic [`DBSP_DW-1:0] dq_drv, dq_out, m0 [16], m1 [16];
	logic [`DBSP_LANES-1:0] sel_n;
	logic [2:0] ph;
	int n_fail = 0;
	int check_count = 0;
	int seed = 39;
	// Shared data wire: port drives it while enabled
	wire [`DBSP_DW-1:0] dq_bus = oe ? dq_out : dq_drv;

	dbsp_ctrl_model i_ctrl (.core_clk_in(core_clk_in), .k_out(k),
		.k_n_out(kn), .phase_out(ph));
	dbsp_port #(.AW(AW)) i_dut (.core_clk_in(core_clk_in),
		.nrst_in(nrst_in), .ce_in(1'b1), .k_in(k), .k_n_in(kn),
		.load_strobe_n_in(load_n), .read_write_in(rw), .addr_in(addr),
		.dq_in(dq_bus), .byte_write_select_n_in(sel_n),
		.pll_disable_n_in(pll_n), .dq_out(dq_out), .dq_oe_out(oe),
		.output_valid_flag_out(vld), .echo_clock_out(eck),
		.echo_clock_n_out(ekn));

	initial forever #12.5 core_clk_in = ~core_clk_in;

	task automatic test_done();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [35:0] e, g);
		check_count++;
		if (g !== e) begin
			n_fail++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask

	function automatic logic [35:0] rnd();
		logic [63:0] r;
		r = {$random(seed), $random(seed)};
		return r[35:0];
	endfunction

	// Reference byte-lane merge: a high select keeps the old lane
	function automatic logic [35:0] mrg(logic [35:0] o, d, logic [3:0] s);
		for (int i = 0; i < 4; i++) begin
			if (!s[i]) o[i*9 +: 9] = d[i*9 +: 9];
		end
		return o;
	endfunction

	// Wait for the falling edge just before the given phase advances
	task automatic wt(input logic [2:0] p);
		do @(negedge core_clk_in); while (ph !== p);
	endtask

	// Load strobe low for one K rise only
	task automatic kload(input logic r, input logic [AW-1:0] a);
		wt(3'h7);
		load_n <= 1'b0;
		rw <= r;
		addr <= a;
		@(negedge core_clk_in);
		load_n <= 1'b1;
		rw <= 1'($random(seed));
		addr <= AW'($random(seed));
	endtask

	task automatic wr(input logic [AW-1:0] a, input logic [3:0] s0, s1);
		logic [35:0] d0, d1;
		d0 = rnd();
		d1 = rnd();
		kload(1'b0, a);
		wt(3'h7);
		dq_drv <= d0;
		sel_n <= s0;
		wt(3'h3);
		dq_drv <= d1;
		sel_n <= s1;
		load_n <= 1'b0; // Stray read strobe on a K# rise
		rw <= 1'b1;
		@(negedge core_clk_in);
		load_n <= 1'b1;
		dq_drv <= rnd(); // Junk outside the beats
		sel_n <= 4'h0;
		m0[a] = mrg(m0[a], d0, s0);
		m1[a] = mrg(m1[a], d1, s1);
		repeat (24) begin
			@(negedge core_clk_in);
			chk("oe_idle", 36'h0, {35'h0, oe});
		end
	endtask

	task automatic rd(input logic [AW-1:0] a, input logic p);
		int b;
		b = p ? 20 : 8;
		pll_n <= p;
		kload(1'b1, a);
		repeat (b - 1) @(negedge core_clk_in);
		chk("oe_early", 36'h0, {35'h0, oe});
		@(negedge core_clk_in);
		chk("beat0", m0[a], dq_out);
		chk("valid", 36'h1, {35'h0, oe & vld});
		chk("echo", {35'h0, k}, {35'h0, eck});
		chk("echo_n", {35'h0, kn}, {35'h0, ekn});
		repeat (4) @(negedge core_clk_in);
		chk("beat1", m1[a], dq_out);
		repeat (4) @(negedge core_clk_in);
		chk("oe_late", 36'h0, {35'h0, oe | vld});
	endtask

	// Main sequence: fill, overwrite lanes at random, read back
	initial begin
		nrst_in = 1'b0;
		load_n = 1'b1;
		rw = 1'b0;
		pll_n = 1'b1;
		addr = '0;
		dq_drv = '0;
		sel_n = 4'hF;
		repeat (2) @(negedge core_clk_in);
		nrst_in <= 1'b1;
		chk("oe_reset", 36'h0, {35'h0, oe});
		for (int i = 0; i < 16; i++) wr(AW'(i), 4'h0, 4'h0);
		for (int i = 0; i < 12; i++) begin
			wr(AW'($random(seed)), 4'($random(seed)), 4'($random(seed)));
		end
		for (int i = 0; i < 16; i++) rd(AW'(i), 1'(i));
		test_done();
	end

	// Watchdog well beyond the expected run of about 1570 cycles
	initial begin
		#250000;
		n_fail++;
		test_done();
	end
endmodule

`default_nettype wire
